// File: src/sdb_sense_builder.sv
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1: Byte 0 is response code 70h, current error, bit 7 zero.
// RULE2: Sense key in byte 2 bits 3..0, upper bits zero.
// RULE3: Successful command gives sense key 0.
// RULE4: Scan refused while busy or other problem gives key 2.
// RULE5: Hardware fault gives key 4 and sets its flags in bytes 18/19.
// RULE6: Illegal parameter gives key 5, no scan, parameters kept.
// RULE7: After reset key 6; refuse all but request sense and inquiry.
// RULE8: Vendor error gives key 9 and sets its vendor flags.
// RULE9: Byte 7 is constant 0Eh, count of bytes after byte 7.
// RULE10: Additional length never follows the host allocation length.
// RULE11: Bytes 18/19 carry the fault flags at fixed bits, others zero.
// RULE12: Key 4 implies at least one hardware flag set.
// RULE13: Correction engine test failure sets its flag, key 4, no scan.
// RULE14: Key 9 implies dim light, no home or over light set.
// RULE15: Dim lamp sets dim light flag; scanning still allowed.
// RULE16: Missing limit switch sets no limit flag and blocks scanning.
// RULE17: Missing home mark sets no home flag; scanning allowed.
// RULE18: Too bright lamp sets over light flag; scanning allowed.
// RULE19: Byte 20 is optical gain, never changes the sense key.
// RULE20: Reserved bytes read zero; host writes zero to reserved fields.
// RULE21: Send bytes in order, stop at allocation length, zero sends none.
module sdb_sense_builder (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   output logic [1:0] s_axi_bresp_out,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   input wire logic [7:0] s_axi_araddr_in,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   input wire logic cmd_valid_in,
   input wire logic [7:0] cmd_opcode_in,
   input wire logic [7:0] cmd_alloc_in,
   output logic cmd_accept_out,
   output logic cmd_refuse_out,
   input wire logic cmd_ok_in,
   input wire logic not_ready_in,
   input wire logic illegal_param_in,
   input wire logic param_commit_in,
   output logic param_commit_out,
   input wire logic scan_req_in,
   input wire logic scan_busy_in,
   output logic scan_go_out,
   input wire logic [7:0] flag18_set_in,
   input wire logic [7:0] flag19_set_in,
   output logic [7:0] sense_data_out,
   output logic sense_valid_out,
   output logic sense_last_out,
   input wire logic sense_ready_in,
   output logic sense_done_out
);
   logic [1:0] rst_sync_r;
   logic rst_n;

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // Sense state
   logic [3:0] key_r;
   logic [3:0] key_nxt;
   logic ua_r;
   logic ua_sent_r;
   logic [7:0] f18_r;
   logic [7:0] f19_r;
   logic [7:0] gain_r;
   logic [3:0] snap_key_r;
   logic [7:0] snap_f18_r;
   logic [7:0] snap_f19_r;
   logic [7:0] snap_gain_r;

   // Register bus state
   logic [7:0] aw_addr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;

   wire aw_hs = s_axi_awvalid_in && s_axi_awready_out;
   wire w_hs = s_axi_wvalid_in && s_axi_wready_out;
   wire b_hs = s_axi_bvalid_out && s_axi_bready_in;
   wire ar_hs = s_axi_arvalid_in && s_axi_arready_out;
   wire r_hs = s_axi_rvalid_out && s_axi_rready_in;
   wire wr_do = !s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out;
   wire wr_hit = (aw_addr_r == sdb_pkg::OFS_CTRL) || (aw_addr_r == sdb_pkg::OFS_STAT) ||
                 (aw_addr_r == sdb_pkg::OFS_FLAG) || (aw_addr_r == sdb_pkg::OFS_GAIN);
   wire clr_flags = wr_do && (aw_addr_r == sdb_pkg::OFS_CTRL) && wstrb_r[0] &&
                    wdata_r[sdb_pkg::CTRL_CLR_BIT];
   wire gain_wr = wr_do && (aw_addr_r == sdb_pkg::OFS_GAIN) && wstrb_r[0];

   // Event decode
   wire hw_set = |(flag18_set_in & sdb_pkg::F18_HW) || |(flag19_set_in & sdb_pkg::F19_HW);
   wire vend_set = |(flag18_set_in & sdb_pkg::F18_VEND) ||
                   |(flag19_set_in & sdb_pkg::F19_VEND);
   wire hw_any = |(f18_r & sdb_pkg::F18_HW) || |(f19_r & sdb_pkg::F19_HW);
   wire busy_deny = scan_req_in && scan_busy_in;
   wire [3:0] key_rep = ua_r ? sdb_pkg::KEY_UA : key_r; // RULE7
   // Vendor flags never block a scan; any hardware flag does
   wire scan_ok = !hw_any && !ua_r && (key_r != sdb_pkg::KEY_ILL); // RULE13 RULE16

   // Command gate
   logic st_busy;
   logic st_done;
   logic [4:0] st_idx;
   wire is_rs = (cmd_opcode_in == sdb_pkg::OP_REQ_SENSE);
   wire is_inq = (cmd_opcode_in == sdb_pkg::OP_INQUIRY);
   wire ua_block = ua_r && !is_rs && !is_inq; // RULE7
   wire refuse = cmd_valid_in && (ua_block || (is_rs && st_busy));
   wire rs_go = cmd_valid_in && is_rs && !st_busy;

   // Sense key: hardware outranks vendor, otherwise newest event wins
   always_comb begin
      key_nxt = key_r;
      if (hw_set) begin
         key_nxt = sdb_pkg::KEY_HW; // RULE5 RULE13
      end else if (vend_set && key_r != sdb_pkg::KEY_HW) begin
         key_nxt = sdb_pkg::KEY_VEND; // RULE8
      end else if (illegal_param_in) begin
         key_nxt = sdb_pkg::KEY_ILL; // RULE6
      end else if (not_ready_in || busy_deny) begin
         key_nxt = sdb_pkg::KEY_NRDY; // RULE4
      end else if (cmd_ok_in) begin
         key_nxt = sdb_pkg::KEY_NONE; // RULE3
      end else if (clr_flags && (key_r == sdb_pkg::KEY_HW || key_r == sdb_pkg::KEY_VEND)) begin
         key_nxt = sdb_pkg::KEY_NONE; // RULE12 RULE14
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         key_r <= sdb_pkg::KEY_NONE;
         ua_r <= 1'b1; // RULE7
         ua_sent_r <= 1'b0;
         f18_r <= 8'h00;
         f19_r <= 8'h00;
      end else begin
         key_r <= key_nxt;
         // Set wins over a simultaneous clear
         f18_r <= (f18_r & ~{8{clr_flags}}) | flag18_set_in; // RULE11 RULE15 RULE17
         f19_r <= ((f19_r & ~{8{clr_flags}}) | flag19_set_in) & sdb_pkg::F19_USED; // RULE11 RULE18
         if (rs_go) begin
            ua_sent_r <= ua_r;
         end
         if (st_done && ua_sent_r) begin
            ua_r <= 1'b0;
            ua_sent_r <= 1'b0;
         end
      end
   end

   // Record frozen at acceptance so bytes stay coherent mid-transfer
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         snap_key_r <= sdb_pkg::KEY_NONE;
         snap_f18_r <= 8'h00;
         snap_f19_r <= 8'h00;
         snap_gain_r <= sdb_pkg::GAIN_RST;
      end else if (rs_go) begin
         snap_key_r <= key_rep;
         snap_f18_r <= f18_r;
         snap_f19_r <= f19_r;
         snap_gain_r <= gain_r; // RULE19
      end
   end

   // Record byte selection; unnamed bytes are reserved and read zero
   wire [7:0] rec_byte =
      (st_idx == sdb_pkg::B_RESP) ? sdb_pkg::RESP_CODE :   // RULE1
      (st_idx == sdb_pkg::B_KEY) ? {4'h0, snap_key_r} :    // RULE2
      (st_idx == sdb_pkg::B_ALEN) ? sdb_pkg::ADD_LEN :     // RULE9 RULE10
      (st_idx == sdb_pkg::B_F18) ? snap_f18_r :            // RULE11
      (st_idx == sdb_pkg::B_F19) ? snap_f19_r :            // RULE11
      (st_idx == sdb_pkg::B_GAIN) ? snap_gain_r : 8'h00;   // RULE19 RULE20

   sdb_stream #(
      .N_BYTES(sdb_pkg::REC_BYTES),
      .IW(5)
   ) u_stream (
      .clk_in(core_clk_in),
      .rst_n_in(rst_n),
      .start_in(rs_go),
      .alloc_in(cmd_alloc_in),
      .byte_in(rec_byte),
      .ready_in(sense_ready_in),
      .idx_out(st_idx),
      .data_out(sense_data_out),
      .valid_out(sense_valid_out),
      .last_out(sense_last_out),
      .done_out(st_done),
      .busy_out(st_busy)
   );
   assign sense_done_out = st_done;

   // Command, scan and parameter outputs
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         cmd_accept_out <= 1'b0;
         cmd_refuse_out <= 1'b0;
         scan_go_out <= 1'b0;
         param_commit_out <= 1'b0;
      end else begin
         cmd_accept_out <= cmd_valid_in && !refuse;
         cmd_refuse_out <= refuse; // RULE7
         scan_go_out <= scan_req_in && !scan_busy_in && scan_ok; // RULE4 RULE16
         param_commit_out <= param_commit_in && !illegal_param_in; // RULE6
      end
   end

   // Register bus: write path
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready_out <= 1'b1;
         s_axi_wready_out <= 1'b1;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= sdb_pkg::RESP_OKAY;
         aw_addr_r <= 8'h00;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
         gain_r <= sdb_pkg::GAIN_RST;
      end else begin
         if (aw_hs) begin
            aw_addr_r <= s_axi_awaddr_in;
            s_axi_awready_out <= 1'b0;
         end
         if (w_hs) begin
            wdata_r <= s_axi_wdata_in;
            wstrb_r <= s_axi_wstrb_in;
            s_axi_wready_out <= 1'b0;
         end
         if (wr_do) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= wr_hit ? sdb_pkg::RESP_OKAY : sdb_pkg::RESP_SLVERR;
         end
         if (gain_wr) begin
            gain_r <= wdata_r[7:0];
         end
         if (b_hs) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
         end
      end
   end

   // Register bus: read path
   wire [31:0] stat_word = {25'h0, st_busy, scan_ok, ua_r, key_rep};
   wire rd_hit = (s_axi_araddr_in == sdb_pkg::OFS_CTRL) ||
                 (s_axi_araddr_in == sdb_pkg::OFS_STAT) ||
                 (s_axi_araddr_in == sdb_pkg::OFS_FLAG) ||
                 (s_axi_araddr_in == sdb_pkg::OFS_GAIN);
   wire [31:0] rd_word =
      (s_axi_araddr_in == sdb_pkg::OFS_STAT) ? stat_word :
      (s_axi_araddr_in == sdb_pkg::OFS_FLAG) ? {16'h0, f19_r, f18_r} :
      (s_axi_araddr_in == sdb_pkg::OFS_GAIN) ? {24'h0, gain_r} : 32'h0;

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready_out <= 1'b1;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0;
         s_axi_rresp_out <= sdb_pkg::RESP_OKAY;
      end else if (ar_hs) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b1;
         s_axi_rdata_out <= rd_word;
         s_axi_rresp_out <= rd_hit ? sdb_pkg::RESP_OKAY : sdb_pkg::RESP_SLVERR;
      end else if (r_hs) begin
         s_axi_rvalid_out <= 1'b0;
         s_axi_arready_out <= 1'b1;
      end
   end

   // Checks: count bytes taken within the current record
   logic [4:0] out_cnt_r;
   wire out_hs = sense_valid_out && sense_ready_in;
   wire cnt_rsvd = (out_cnt_r != sdb_pkg::B_RESP) && (out_cnt_r != sdb_pkg::B_KEY) &&
                   (out_cnt_r != sdb_pkg::B_ALEN) && (out_cnt_r != sdb_pkg::B_F18) &&
                   (out_cnt_r != sdb_pkg::B_F19) && (out_cnt_r != sdb_pkg::B_GAIN);

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         out_cnt_r <= 5'h00;
      end else if (out_hs) begin
         out_cnt_r <= sense_last_out ? 5'h00 : out_cnt_r + 5'h01;
      end
   end

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n);

   property p_resp_code;
      sense_valid_out && out_cnt_r == sdb_pkg::B_RESP |-> sense_data_out == sdb_pkg::RESP_CODE;
   endproperty
   a_resp_code: assert property (p_resp_code) else $error("bad response code"); // RULE1

   property p_key_byte;
      sense_valid_out && out_cnt_r == sdb_pkg::B_KEY |-> sense_data_out[7:4] == 4'h0;
   endproperty
   a_key_byte: assert property (p_key_byte) else $error("key byte upper bits set"); // RULE2

   property p_add_len;
      sense_valid_out && out_cnt_r == sdb_pkg::B_ALEN |-> sense_data_out == sdb_pkg::ADD_LEN;
   endproperty
   a_add_len: assert property (p_add_len) else $error("bad additional length"); // RULE9

   property p_rsvd;
      sense_valid_out && cnt_rsvd |-> sense_data_out == 8'h00;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved byte not zero"); // RULE20

   property p_f19_rsvd;
      sense_valid_out && out_cnt_r == sdb_pkg::B_F19 |->
         (sense_data_out & ~sdb_pkg::F19_USED) == 8'h00;
   endproperty
   a_f19_rsvd: assert property (p_f19_rsvd) else $error("byte 19 reserved bit set"); // RULE11

   property p_ok;
      cmd_ok_in && !hw_set && !vend_set && !illegal_param_in && !not_ready_in && !busy_deny
         |=> key_r == sdb_pkg::KEY_NONE;
   endproperty
   a_ok: assert property (p_ok) else $error("key not cleared on success"); // RULE3

   property p_hw_flag;
      key_r == sdb_pkg::KEY_HW |-> hw_any;
   endproperty
   a_hw_flag: assert property (p_hw_flag) else $error("key 4 without flag"); // RULE12

   property p_vend_flag;
      key_r == sdb_pkg::KEY_VEND |-> |(f18_r & sdb_pkg::F18_VEND) || |(f19_r & sdb_pkg::F19_VEND);
   endproperty
   a_vend_flag: assert property (p_vend_flag) else $error("key 9 without flag"); // RULE14

   property p_ua_refuse;
      ua_r && cmd_valid_in && !is_rs && !is_inq |=> cmd_refuse_out && !cmd_accept_out;
   endproperty
   a_ua_refuse: assert property (p_ua_refuse) else $error("command not refused"); // RULE7

   property p_no_limit;
      f18_r[sdb_pkg::BIT_NO_LIMIT] |=> !scan_go_out;
   endproperty
   a_no_limit: assert property (p_no_limit) else $error("scan with no limit"); // RULE16

   property p_illegal;
      illegal_param_in |=> !param_commit_out &&
         (key_r == sdb_pkg::KEY_ILL || $past(hw_set) || $past(vend_set));
   endproperty
   a_illegal: assert property (p_illegal) else $error("illegal parameter accepted"); // RULE6

   property p_zero_len;
      rs_go && cmd_alloc_in == 8'h00 |=> sense_done_out && !sense_valid_out;
   endproperty
   a_zero_len: assert property (p_zero_len) else $error("zero length sent data"); // RULE21

   c_full_rec: cover property (out_hs && sense_last_out && out_cnt_r == 5'h15);
   c_ua_refuse: cover property (ua_r && cmd_valid_in && !is_rs && !is_inq);
   c_hw_key: cover property (rs_go && key_rep == sdb_pkg::KEY_HW);
   c_short: cover property (out_hs && sense_last_out && out_cnt_r == 5'h02);
endmodule : sdb_sense_builder
`default_nettype wire

// File: src/sdb_pkg.sv
package sdb_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_FLAG = 8'h08;
   localparam logic [7:0] OFS_GAIN = 8'h0c;
   localparam int CTRL_CLR_BIT = 0;
   localparam logic [7:0] GAIN_RST = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Sense record layout
   localparam int REC_BYTES = 22;
   localparam logic [7:0] RESP_CODE = 8'h70;
   localparam logic [7:0] ADD_LEN = 8'h0e;
   localparam logic [4:0] B_RESP = 5'h00;
   localparam logic [4:0] B_KEY = 5'h02;
   localparam logic [4:0] B_ALEN = 5'h07;
   localparam logic [4:0] B_F18 = 5'h12;
   localparam logic [4:0] B_F19 = 5'h13;
   localparam logic [4:0] B_GAIN = 5'h14;

   // Sense keys
   localparam logic [3:0] KEY_NONE = 4'h0;
   localparam logic [3:0] KEY_NRDY = 4'h2;
   localparam logic [3:0] KEY_HW = 4'h4;
   localparam logic [3:0] KEY_ILL = 4'h5;
   localparam logic [3:0] KEY_UA = 4'h6;
   localparam logic [3:0] KEY_VEND = 4'h9;

   // Flag byte masks: byte 18 and byte 19
   localparam logic [7:0] F18_HW = 8'h5f;
   localparam logic [7:0] F18_VEND = 8'ha0;
   localparam logic [7:0] F19_HW = 8'h10;
   localparam logic [7:0] F19_VEND = 8'h02;
   localparam logic [7:0] F19_USED = 8'h12;
   localparam int BIT_NO_LIMIT = 4;

   localparam logic [7:0] OP_REQ_SENSE = 8'h03;
   localparam logic [7:0] OP_INQUIRY = 8'h12;
endpackage : sdb_pkg

// File: src/sdb_stream.sv
`timescale 1ns/1ps
`default_nettype none
module sdb_stream #(
   parameter int N_BYTES = 22,
   parameter int IW = 5
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic start_in,
   input wire logic [7:0] alloc_in,
   input wire logic [7:0] byte_in,
   input wire logic ready_in,
   output logic [IW-1:0] idx_out,
   output logic [7:0] data_out,
   output logic valid_out,
   output logic last_out,
   output logic done_out,
   output logic busy_out
);
   if (N_BYTES < 1 || N_BYTES > 255 || N_BYTES > (1 << IW)) begin : g_bad_len
      $error("sdb_stream: N_BYTES does not fit");
   end

   logic [7:0] left_r;
   logic [7:0] n_first;
   logic adv;
   logic take;

   assign n_first = (alloc_in > 8'(N_BYTES)) ? 8'(N_BYTES) : alloc_in;
   assign adv = busy_out && (left_r != 8'h00) && (!valid_out || ready_in);
   assign take = valid_out && ready_in;

   // One-deep output stage; byte_in is the record byte at idx_out
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         idx_out <= '0;
         left_r <= 8'h00;
         data_out <= 8'h00;
         valid_out <= 1'b0;
         last_out <= 1'b0;
         done_out <= 1'b0;
         busy_out <= 1'b0;
      end else if (start_in && !busy_out) begin
         idx_out <= '0;
         left_r <= n_first;
         busy_out <= (n_first != 8'h00); // RULE21
         done_out <= (n_first == 8'h00); // RULE21
      end else begin
         done_out <= 1'b0;
         if (adv) begin
            data_out <= byte_in; // RULE21
            valid_out <= 1'b1;
            last_out <= (left_r == 8'h01);
            idx_out <= idx_out + IW'(1);
            left_r <= left_r - 8'h01;
         end else if (take) begin
            valid_out <= 1'b0;
            last_out <= 1'b0;
            if (last_out) begin
               busy_out <= 1'b0;
               done_out <= 1'b1;
            end
         end
      end
   end
endmodule : sdb_stream
`default_nettype wire

// File: test/sdb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdb_host_model (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic stall_in,
   input wire logic [7:0] data_in,
   input wire logic valid_in,
   input wire logic last_in,
   output logic ready_out
);
   logic [7:0] rx_q[$];
   int last_pos;
   logic [4:0] lfsr_r;
   // Pseudo-random back-pressure while stalling is enabled
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lfsr_r <= 5'h1f;
         ready_out <= 1'b0;
         last_pos <= -1;
      end else begin
         lfsr_r <= {lfsr_r[3:0], lfsr_r[4] ^ lfsr_r[2]};
         ready_out <= !stall_in || lfsr_r[0];
         if (valid_in && ready_out) begin
            if (last_in) last_pos <= rx_q.size();
            rx_q.push_back(data_in);
         end
      end
   end
endmodule : sdb_host_model
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk, rst_n, awv, wv, bre, arv, rre, cv, busy, stall;
   logic [7:0] awa, ara, op, al, f18i, f19i;
   logic [31:0] wd, d;
   logic [4:0] ev;
   logic [1:0] r;
   wire logic awr, wr, bv, arr, rv, acc, rfs, pco, go, sv, sl, sd, srdy;
   wire logic [1:0] br, rr;
   wire logic [31:0] rd;
   wire logic [7:0] sdat;
   int err_count, n_tests, key, f18, f19, gain, ua, seed, a;

   sdb_sense_builder dut (.core_clk_in(clk), .resetn_in(rst_n), .s_axi_awvalid_in(awv),
      .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv),
      .s_axi_wready_out(wr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf),
      .s_axi_bvalid_out(bv), .s_axi_bready_in(bre), .s_axi_bresp_out(br),
      .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
      .s_axi_rvalid_out(rv), .s_axi_rready_in(rre), .s_axi_rdata_out(rd),
      .s_axi_rresp_out(rr), .cmd_valid_in(cv), .cmd_opcode_in(op), .cmd_alloc_in(al),
      .cmd_accept_out(acc), .cmd_refuse_out(rfs), .cmd_ok_in(ev[0]), .not_ready_in(ev[1]),
      .illegal_param_in(ev[2]), .param_commit_in(ev[3]), .param_commit_out(pco),
      .scan_req_in(ev[4]), .scan_busy_in(busy), .scan_go_out(go), .flag18_set_in(f18i),
      .flag19_set_in(f19i), .sense_data_out(sdat), .sense_valid_out(sv),
      .sense_last_out(sl), .sense_ready_in(srdy), .sense_done_out(sd));

   sdb_host_model host (.clk_in(clk), .rst_n_in(rst_n), .stall_in(stall), .data_in(sdat),
      .valid_in(sv), .last_in(sl), .ready_out(srdy));

   initial begin
      clk = 1'b0;
      forever #4 clk = !clk;
   end

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_val

   task automatic complete_run;
      $display("checks=%0d errors=%0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run

   task automatic hang;
      err_count++;
      complete_run();
   endtask : hang

   task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt);
      int n;
      @(posedge clk);
      awv <= 1'b1;
      wv <= 1'b1;
      awa <= ad;
      wd <= dt;
      bre <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
         if (bv) break;
      end
      if (n == 40) hang();
      r = br;
      bre <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] ad);
      int n;
      @(posedge clk);
      arv <= 1'b1;
      ara <= ad;
      rre <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
         if (rv) break;
      end
      if (n == 40) hang();
      d = rd;
      r = rr;
      rre <= 1'b0;
   endtask : axi_rd

   function automatic logic [7:0] rec_b(input int i);
      case (i)
         0: return sdb_pkg::RESP_CODE;
         2: return 8'(ua ? 6 : key);
         7: return sdb_pkg::ADD_LEN;
         18: return 8'(f18);
         19: return 8'(f19);
         20: return 8'(gain);
         default: return 8'h00;
      endcase
   endfunction : rec_b

   task automatic cmd(input logic [7:0] o, input logic [7:0] n, input logic exp);
      @(posedge clk);
      cv <= 1'b1;
      op <= o;
      al <= n;
      @(posedge clk);
      cv <= 1'b0;
      #1;
      check_val({acc, rfs}, {exp, !exp});
   endtask : cmd

   task automatic sense(input int n);
      int i, m, base;
      base = host.rx_q.size();
      cmd(sdb_pkg::OP_REQ_SENSE, 8'(n), 1'b1);
      for (i = 0; i < 300; i++) begin
         @(posedge clk);
         if (sd) break;
      end
      if (i == 300) hang();
      m = (n > 22) ? 22 : n;
      check_val(host.rx_q.size() - base, m);
      for (i = 0; i < m; i++) begin
         check_val(host.rx_q[base + i], rec_b(i));
      end
      if (m > 0) check_val(host.last_pos, base + m - 1);
      ua = 0;
   endtask : sense

   task automatic evt(input logic [4:0] e, input logic [7:0] a18, input logic [7:0] a19,
      input logic b);
      logic hw, vd, g, ok;
      hw = |(a18 & sdb_pkg::F18_HW) || |(a19 & sdb_pkg::F19_HW);
      vd = |(a18 & sdb_pkg::F18_VEND) || |(a19 & sdb_pkg::F19_VEND);
      g = e[4] && !b && !ua && key != 5 && (f18 & sdb_pkg::F18_HW) == 0 &&
         (f19 & sdb_pkg::F19_HW) == 0;
      @(posedge clk);
      ev <= e;
      f18i <= a18;
      f19i <= a19;
      busy <= b;
      @(posedge clk);
      ev <= 5'h00;
      f18i <= 8'h00;
      f19i <= 8'h00;
      busy <= 1'b0;
      #1;
      check_val({go, pco}, {g, e[3] && !e[2]});
      f18 |= a18;
      f19 |= a19 & sdb_pkg::F19_USED;
      if (hw) key = 4;
      else if (vd && key != 4) key = 9;
      else if (e[2]) key = 5;
      else if (e[1] || (e[4] && b)) key = 2;
      else if (e[0]) key = 0;
      ok = !ua && key != 5 && (f18 & sdb_pkg::F18_HW) == 0 && (f19 & sdb_pkg::F19_HW) == 0;
      repeat (2) @(posedge clk);
      axi_rd(sdb_pkg::OFS_STAT);
      check_val(d, {25'h0, 1'b0, ok, ua[0], 4'(ua ? 6 : key)});
      axi_rd(sdb_pkg::OFS_FLAG);
      check_val(d, {16'h0, 8'(f19), 8'(f18)});
   endtask : evt

   initial begin
      {rst_n, awv, wv, bre, arv, rre, cv, busy, stall} = '0;
      {awa, ara, op, al, f18i, f19i, wd, ev} = '0;
      {err_count, n_tests, key, f18, f19, gain} = '0;
      ua = 1;
      seed = $urandom(86341);
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      evt(5'h10, 8'h00, 8'h00, 1'b0);
      cmd(8'h1b, 8'h00, 1'b0);
      cmd(sdb_pkg::OP_INQUIRY, 8'h00, 1'b1);
      sense(22);
      evt(5'h01, 8'h00, 8'h00, 1'b0);
      sense(22);
      evt(5'h00, 8'h10, 8'h00, 1'b0);
      evt(5'h10, 8'h00, 8'h00, 1'b0);
      evt(5'h00, 8'h00, 8'hfd, 1'b0);
      evt(5'h10, 8'h00, 8'h00, 1'b0);
      sense(22);
      axi_wr(sdb_pkg::OFS_CTRL, 32'h00000001);
      f18 = 0;
      f19 = 0;
      key = 0;
      check_val(32'(r), 32'(sdb_pkg::RESP_OKAY));
      evt(5'h00, 8'ha0, 8'h02, 1'b0);
      evt(5'h10, 8'h00, 8'h00, 1'b0);
      sense(22);
      gain = $urandom_range(1, 255);
      axi_wr(sdb_pkg::OFS_GAIN, 32'(gain));
      axi_rd(sdb_pkg::OFS_GAIN);
      check_val(d, 32'(gain));
      check_val(32'(r), 32'(sdb_pkg::RESP_OKAY));
      stall <= 1'b1;
      a = $urandom_range(21, 40);
      sense(a);
      a = $urandom_range(1, 20);
      sense(a);
      sense(0);
      stall <= 1'b0;
      evt(5'h0c, 8'h00, 8'h00, 1'b0);
      evt(5'h10, 8'h00, 8'h00, 1'b0);
      evt(5'h08, 8'h00, 8'h00, 1'b0);
      evt(5'h02, 8'h00, 8'h00, 1'b0);
      evt(5'h01, 8'h00, 8'h00, 1'b0);
      evt(5'h10, 8'h00, 8'h00, 1'b1);
      sense(22);
      axi_rd(8'h40);
      check_val(32'(r), 32'(sdb_pkg::RESP_SLVERR));
      check_val(d, 32'h00000000);
      axi_wr(8'h44, 32'h00000000);
      check_val(32'(r), 32'(sdb_pkg::RESP_SLVERR));
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
